// *** src/obdls_pkg.sv ***
// Constants, carrier structs and state type for the OBD link supervisor.
package obdls_pkg;

    // ----------------------------------------------------------------
    // Register map and fields
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_WPER = 8'h04;
    localparam logic [7:0] ADDR_WHDR = 8'h08;
    localparam logic [7:0] ADDR_WDAT = 8'h0c;
    localparam logic [7:0] ADDR_STAT = 8'h10;
    localparam logic [7:0] ADDR_ERR  = 8'h14;
    localparam int CTRL_LINK_BIT = 0;
    localparam int CTRL_AUTO_BIT = 1;
    localparam int WDAT_LEN_LSB  = 24;
    localparam int STAT_CNT_LSB  = 0;
    localparam int STAT_WK_LSB   = 12;
    localparam int STAT_HOLD_BIT = 14;
    localparam int STAT_BUSY_BIT = 15;

    // ----------------------------------------------------------------
    // Reset values and timing
    // ----------------------------------------------------------------
    localparam int          CLK_HZ      = 250_000_000;
    localparam int          WAKE_DEF_S  = 3;
    localparam logic [15:0] WAKE_DEF_MS = 16'(WAKE_DEF_S * 1000);
    localparam int          CYC_PER_MS  = CLK_HZ / 1000;
    localparam logic [15:0] REPLY_WIN_MS = 16'h0032;
    localparam int          FB_NS       = 1000;
    localparam int          FB_CYC      = (FB_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [23:0] WAKE_DEF_HDR = 24'h000000;
    localparam logic [23:0] WAKE_DEF_DAT = 24'h000000;
    localparam logic [1:0]  WAKE_DEF_LEN = 2'h1;
    localparam int          BUF_DEPTH   = 256;
    localparam int          BUF_AW      = 8;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ERR_NONE, ERR_BUF_FULL, ERR_FB, ERR_CMD, ERR_NO_CONN, ERR_BUS_BUSY, ERR_BUS,
        ERR_CAN, ERR_RX_MARK, ERR_DATA_MARK, ERR_DATA, ERR_NO_DATA
    } obdls_err_e;

    typedef enum logic [1:0] {WK_IDLE, WK_SEND, WK_REPLY} obdls_wk_e;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } obdls_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } obdls_apb_rsp_s;

    typedef struct packed {
        logic bus_busy;
        logic bus_pulse;
        logic can_fail;
        logic can_rx_err;
        logic line_bad;
        logic data_lost;
        logic timeout;
        logic search_fail;
        logic cmd_bad;
    } obdls_fault_s;

    typedef struct packed {
        logic           link_up;
        logic           auto_mode;
        logic [15:0]    wper;
        logic [23:0]    whdr_pend;
        logic [23:0]    whdr;
        logic [23:0]    wdat;
        logic [1:0]     wlen;
        obdls_wk_e      wk;
        logic [2:0]     idx;
        logic [17:0]    pre;
        logic [15:0]    ms;
        logic [7:0]     wr;
        logic [7:0]     rd;
        logic [8:0]     cnt;
        logic [7:0]     tx_data;
        logic           tx_valid;
        logic [7:0]     wake_data;
        logic           wake_valid;
        logic           bus_out;
        logic           fb_lock;
        logic [8:0]     fb_cnt;
        logic           busy;
        logic           hold;
        logic           abort;
        logic           rxd_prev;
        obdls_err_e     err_code;
        logic           err_valid;
        obdls_err_e     err_last;
        obdls_apb_rsp_s apb;
    } obdls_state_s;

endpackage

// *** src/obdls_top.sv ***
// Keep-alive, fault reporting, host buffer and busy handshake of the OBD link supervisor.
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module obdls_top #(
    parameter int unsigned MS_CYC = obdls_pkg::CYC_PER_MS  // Clock cycles per millisecond.
) (
    input  wire logic                  clk,           // System clock.
    input  wire logic                  rst,           // Synchronous reset, active high.
    input  wire obdls_pkg::obdls_apb_req_s apb_i,     // APB request.
    output var  obdls_pkg::obdls_apb_rsp_s apb_o,     // APB response.
    input  wire obdls_pkg::obdls_fault_s   fault_i,   // Fault events from the interpreter.
    input  wire logic                  link_act,      // Ordinary request or response traffic.
    input  wire logic                  work_busy,     // Interpreter is processing.
    input  wire logic [7:0]            rx_byte,       // Host-bound byte.
    input  wire logic                  rx_valid,      // Host-bound byte valid.
    output logic [7:0]                 host_tx_data,  // Byte to host UART.
    output logic                       host_tx_valid, // Byte to host valid.
    input  wire logic                  host_tx_ready, // Host UART takes byte.
    output logic [7:0]                 wake_data,     // Keep-alive byte to link.
    output logic                       wake_valid,    // Keep-alive byte valid.
    input  wire logic                  wake_ready,    // Link takes keep-alive byte.
    input  wire logic                  drv_req,       // Request to energise bus output.
    input  wire logic                  fb_in,         // Bus input seen by the device.
    output logic                       bus_out,       // Bus output drive.
    output obdls_pkg::obdls_err_e      err_code,      // Error report code.
    output logic                       err_valid,     // Error report pulse.
    output logic                       busy,          // Busy to host.
    input  wire logic                  rts_n,         // Request to send, active low.
    input  wire logic                  host_rxd,      // Serial receive line.
    output logic                       abort          // Abandon current work, pulse.
);

    // ----------------------------------------------------------------
    // State and memory
    // ----------------------------------------------------------------
    obdls_pkg::obdls_state_s s;
    obdls_pkg::obdls_state_s n;
    logic [7:0] mem [obdls_pkg::BUF_DEPTH];
    logic       push;
    logic       acc;
    logic       pop;
    logic       fb_evt;
    logic       full_evt;
    logic       rxd_fall;
    logic       setup;
    logic       wr_ok;
    logic [2:0] last_idx;

    function automatic logic [7:0] msg_byte(logic [23:0] h, logic [23:0] d,
                                            logic [1:0] len, logic [2:0] i);
        logic [7:0] sum;
        logic [2:0] k;
        sum = h[7:0] + h[15:8] + h[23:16];
        for (int j = 0; j < 3; j++)
        begin
            if (2'(j) < len)
            begin
                sum = sum + d[8*j +: 8];
            end
        end
        k = i - 3'h3;
        if (i < 3'h3)
        begin
            msg_byte = h[{i[1:0], 3'h0} +: 8];
        end
        else if (k < {1'b0, len})
        begin
            msg_byte = d[{k[1:0], 3'h0} +: 8];
        end
        else
        begin
            msg_byte = sum;
        end
    endfunction

    function automatic logic suppressed(obdls_pkg::obdls_err_e c);
        suppressed = (c == obdls_pkg::ERR_BUS_BUSY) || (c == obdls_pkg::ERR_BUS)
                  || (c == obdls_pkg::ERR_CAN) || (c == obdls_pkg::ERR_FB);
    endfunction

    function automatic obdls_pkg::obdls_err_e pick(logic [10:0] v, logic auto_on);
        pick = obdls_pkg::ERR_NONE;
        for (int j = 10; j >= 0; j--)
        begin
            if (v[j] && !(auto_on && suppressed(obdls_pkg::obdls_err_e'(4'(j + 1)))))
            begin
                pick = obdls_pkg::obdls_err_e'(4'(j + 1));
            end
        end
    endfunction

    assign last_idx = 3'h3 + {1'b0, s.wlen};
    assign rxd_fall = s.rxd_prev && !host_rxd;
    assign setup    = apb_i.psel && !apb_i.penable;
    assign wr_ok    = apb_i.psel && apb_i.penable && s.apb.pready && apb_i.pwrite
                   && !s.apb.pslverr;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        n = s;
        n.abort = 1'b0;
        n.apb.pready = 1'b0;
        n.apb.pslverr = 1'b0;
        n.rxd_prev = host_rxd;
        fb_evt = 1'b0;
        // APB: setup cycle prepares the answer, access cycle completes at once.
        if (setup)
        begin
            n.apb.pready = 1'b1;
            n.apb.prdata = '0;
            case (apb_i.paddr)
                obdls_pkg::ADDR_CTRL:
                begin
                    n.apb.prdata[obdls_pkg::CTRL_LINK_BIT] = s.link_up;
                    n.apb.prdata[obdls_pkg::CTRL_AUTO_BIT] = s.auto_mode;
                end
                obdls_pkg::ADDR_WPER: n.apb.prdata[15:0] = s.wper;
                obdls_pkg::ADDR_WHDR: n.apb.prdata[23:0] = s.whdr;
                obdls_pkg::ADDR_WDAT:
                begin
                    n.apb.prdata[23:0] = s.wdat;
                    n.apb.prdata[obdls_pkg::WDAT_LEN_LSB +: 2] = s.wlen;
                    // Refuse a message with no data bytes.
                    n.apb.pslverr = apb_i.pwrite
                                 && (apb_i.pwdata[obdls_pkg::WDAT_LEN_LSB +: 2] == 2'h0);
                end
                obdls_pkg::ADDR_STAT:
                begin
                    n.apb.prdata[obdls_pkg::STAT_CNT_LSB +: 9] = s.cnt;
                    n.apb.prdata[obdls_pkg::STAT_WK_LSB +: 2] = s.wk;
                    n.apb.prdata[obdls_pkg::STAT_HOLD_BIT] = s.hold;
                    n.apb.prdata[obdls_pkg::STAT_BUSY_BIT] = s.busy;
                end
                obdls_pkg::ADDR_ERR: n.apb.prdata[3:0] = s.err_last;
                default: n.apb.pslverr = 1'b1;
            endcase
        end
        if (wr_ok)
        begin
            case (apb_i.paddr)
                obdls_pkg::ADDR_CTRL:
                begin
                    n.link_up = apb_i.pwdata[obdls_pkg::CTRL_LINK_BIT];
                    n.auto_mode = apb_i.pwdata[obdls_pkg::CTRL_AUTO_BIT];
                end
                obdls_pkg::ADDR_WPER: n.wper = apb_i.pwdata[15:0];
                obdls_pkg::ADDR_WHDR: n.whdr_pend = apb_i.pwdata[23:0];
                obdls_pkg::ADDR_WDAT:
                begin
                    // Header and data change together; a write while a keep-alive is being sent changes its remaining bytes.
                    n.whdr = s.whdr_pend;
                    n.wdat = apb_i.pwdata[23:0];
                    n.wlen = apb_i.pwdata[obdls_pkg::WDAT_LEN_LSB +: 2];
                end
                default: n.link_up = s.link_up;
            endcase
        end

        // ------------------------------------------------------------
        // Busy handshake
        // ------------------------------------------------------------
        if (!rts_n && s.busy && !s.hold)
        begin
            n.hold = 1'b1;
            n.busy = 1'b0;
            n.abort = 1'b1;
            n.wk = obdls_pkg::WK_IDLE;
        end
        else if (s.hold)
        begin
            n.busy = 1'b0;
            n.hold = !rxd_fall;
        end
        else
        begin
            n.busy = work_busy || (s.wk != obdls_pkg::WK_IDLE);
        end

        // ------------------------------------------------------------
        // Keep-alive sequencer
        // ------------------------------------------------------------
        n.pre = (s.pre == 18'(MS_CYC - 1)) ? 18'h0 : s.pre + 18'h1;
        if (s.pre == 18'(MS_CYC - 1) && s.ms != 16'hffff)
        begin
            n.ms = s.ms + 16'h1;
        end
        case (s.wk)
            obdls_pkg::WK_IDLE:
            begin
                if (!s.link_up || link_act || rx_valid || rxd_fall)
                begin
                    n.pre = '0;
                    n.ms = '0;
                end
                else if (s.ms >= s.wper && !s.hold && !n.hold)
                begin
                    n.wk = obdls_pkg::WK_SEND;
                    n.idx = '0;
                end
            end
            obdls_pkg::WK_SEND:
            begin
                if (s.wake_valid && wake_ready)
                begin
                    if (s.idx == last_idx)
                    begin
                        n.wk = obdls_pkg::WK_REPLY;
                        n.pre = '0;
                        n.ms = '0;
                    end
                    else
                    begin
                        n.idx = s.idx + 3'h1;
                    end
                end
            end
            obdls_pkg::WK_REPLY:
            begin
                if (s.ms >= obdls_pkg::REPLY_WIN_MS)
                begin
                    n.wk = obdls_pkg::WK_IDLE;
                    n.pre = '0;
                    n.ms = '0;
                end
            end
            default: n.wk = obdls_pkg::WK_IDLE;
        endcase
        if (n.hold && !s.hold)
        begin
            n.wk = obdls_pkg::WK_IDLE;
        end
        n.wake_valid = (n.wk == obdls_pkg::WK_SEND);
        n.wake_data = msg_byte(n.whdr, n.wdat, n.wlen, n.idx);

        // ------------------------------------------------------------
        // Bus output feedback check
        // ------------------------------------------------------------
        if (!drv_req)
        begin
            n.fb_lock = 1'b0;
            n.fb_cnt = '0;
            n.bus_out = 1'b0;
        end
        else if (s.fb_lock)
        begin
            n.bus_out = 1'b0;
        end
        else if (s.bus_out && !fb_in)
        begin
            n.fb_cnt = s.fb_cnt + 9'h1;
            n.bus_out = 1'b1;
            if (s.fb_cnt == 9'(obdls_pkg::FB_CYC - 1))
            begin
                n.fb_lock = 1'b1;
                n.bus_out = 1'b0;
                fb_evt = 1'b1;
            end
        end
        else
        begin
            n.fb_cnt = '0;
            n.bus_out = 1'b1;
        end

        // ------------------------------------------------------------
        // Host buffer
        // ------------------------------------------------------------
        push = rx_valid && (s.wk != obdls_pkg::WK_REPLY);
        full_evt = push && (s.cnt == 9'(obdls_pkg::BUF_DEPTH));
        acc = push && !full_evt;
        pop = (s.cnt != 9'h0) && (!s.tx_valid || host_tx_ready);
        if (pop)
        begin
            n.tx_data = mem[s.rd];
            n.tx_valid = 1'b1;
            n.rd = s.rd + 8'h1;
        end
        else if (host_tx_ready)
        begin
            n.tx_valid = 1'b0;
        end
        if (acc)
        begin
            n.wr = s.wr + 8'h1;
        end
        n.cnt = s.cnt + {8'h0, acc} - {8'h0, pop};

        // ------------------------------------------------------------
        // Error reports, one per cycle, highest priority first
        // ------------------------------------------------------------
        n.err_code = pick({fault_i.timeout, fault_i.data_lost, fault_i.line_bad,
                           fault_i.can_rx_err, fault_i.can_fail, fault_i.bus_pulse,
                           fault_i.bus_busy, fault_i.search_fail, fault_i.cmd_bad,
                           fb_evt, full_evt}, s.auto_mode);
        n.err_valid = (n.err_code != obdls_pkg::ERR_NONE);
        if (n.err_valid)
        begin
            n.err_last = n.err_code;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s <= '0;
            s.wper <= obdls_pkg::WAKE_DEF_MS;
            s.whdr <= obdls_pkg::WAKE_DEF_HDR;
            s.whdr_pend <= obdls_pkg::WAKE_DEF_HDR;
            s.wdat <= obdls_pkg::WAKE_DEF_DAT;
            s.wlen <= obdls_pkg::WAKE_DEF_LEN;
            s.rxd_prev <= 1'b1;
        end
        else
        begin
            s <= n;
        end
    end

    always_ff @(posedge clk)
    begin
        if (acc)
        begin
            mem[s.wr] <= rx_byte;
        end
    end

    assign apb_o         = s.apb;
    assign host_tx_data  = s.tx_data;
    assign host_tx_valid = s.tx_valid;
    assign wake_data     = s.wake_data;
    assign wake_valid    = s.wake_valid;
    assign bus_out       = s.bus_out;
    assign err_code      = s.err_code;
    assign err_valid     = s.err_valid;
    assign busy          = s.busy;
    assign abort         = s.abort;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    chk_wake_link_gate: assert property (wake_valid |-> s.link_up)
        else $error("keep-alive sent without link");
    chk_wake_start: assert property (s.wk == obdls_pkg::WK_IDLE && s.link_up && !link_act
        && !rx_valid && !rxd_fall && !s.hold && rts_n && s.ms >= s.wper
        |=> s.wk == obdls_pkg::WK_SEND ##1 wake_valid)
        else $error("keep-alive not started at interval");
    chk_timer_restart: assert property (s.wk == obdls_pkg::WK_IDLE && link_act
        |=> s.ms == 16'h0 && s.pre == 18'h0)
        else $error("traffic did not restart timer");
    chk_reply_drop: assert property (s.wk == obdls_pkg::WK_REPLY && !pop
        |=> s.cnt == $past(s.cnt))
        else $error("keep-alive reply reached buffer");
    chk_cksum_last: assert property (wake_valid && s.idx == last_idx
        |-> wake_data == msg_byte(s.whdr, s.wdat, s.wlen, 3'h7))
        else $error("keep-alive checksum wrong");
    chk_buf_full: assert property (full_evt && !pop
        |=> err_valid && err_code == obdls_pkg::ERR_BUF_FULL && s.cnt == 9'h100)
        else $error("buffer overflow not reported");
    chk_fb_cut: assert property (err_valid && err_code == obdls_pkg::ERR_FB
        |-> !bus_out ##1 (!bus_out || !drv_req || $past(!drv_req)))
        else $error("feedback fault left output on");
    chk_auto_quiet: assert property (err_valid && $past(s.auto_mode)
        |-> !suppressed(err_code))
        else $error("report not suppressed in auto mode");
    chk_busy_drop: assert property (busy && !rts_n && !s.hold
        |=> !busy && abort && s.hold)
        else $error("busy not dropped on request");
    chk_busy_stay: assert property (s.hold && !rxd_fall |=> !busy [*2])
        else $error("busy returned before command");
    chk_cmd_report: assert property (fault_i.cmd_bad && !full_evt && !fb_evt
        |=> err_valid && err_code == obdls_pkg::ERR_CMD)
        else $error("bad command not answered");

    cov_wake_sent: cover property (s.wk == obdls_pkg::WK_SEND ##1 s.wk == obdls_pkg::WK_REPLY);
    cov_buf_full: cover property (full_evt);
    cov_rts_hold: cover property (abort ##[1:20] s.hold && rxd_fall);
    cov_fb_fault: cover property (err_valid && err_code == obdls_pkg::ERR_FB);

endmodule

`default_nettype wire

// *** dv/obdls_host_model.sv ***
// Host UART and handshake pin model facing the OBD link supervisor.
`timescale 1ns/1ps
`default_nettype none
module obdls_host_model (
    input  wire logic       clk,      // System clock.
    input  wire logic [7:0] tx_data,  // Byte from device.
    input  wire logic       tx_valid, // Byte valid.
    output logic            tx_ready, // Host takes byte.
    input  wire logic       busy,     // Device busy.
    output logic            rts_n,    // Request to send, active low.
    output logic            rxd       // Serial line into the device.
);
    logic       stall;
    logic [7:0] got[$];
    initial
    begin
        stall = 1'b0;
        rts_n = 1'b1;
        rxd   = 1'b1;
    end
    assign tx_ready = !stall;
    always @(posedge clk)
        if (tx_valid && tx_ready)
            got.push_back(tx_data);
    // Waits for busy with a bound so a stuck device cannot hang the host.
    task automatic rts_req();
        int n;
        @(posedge clk);
        rts_n <= 1'b0;
        n = 0;
        while (busy !== 1'b0 && n < 50)
        begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        rts_n <= 1'b1;
    endtask
    task automatic cmd();
        @(posedge clk);
        rxd <= 1'b0;
        repeat (4) @(posedge clk);
        rxd <= 1'b1;
    endtask
endmodule
`default_nettype wire

// *** dv/obdls_top_tb_top.sv ***
// Self-checking testbench of the OBD link supervisor.
`timescale 1ns/1ps
`default_nettype none
module obdls_top_tb_top;
    logic clk, rst, la, wb, rv, wr, dr, fb, htv, htr, wkv, bo, ev, by, rn, rxd, ab, sl;
    logic [7:0] rb, htd, wkd;
    logic [31:0] rd;
    logic [7:0] wq[$];
    logic [3:0] eq[$];
    int errors, samples_checked, cyc, aborts;
    obdls_pkg::obdls_apb_req_s req;
    obdls_pkg::obdls_apb_rsp_s rsp;
    obdls_pkg::obdls_fault_s flt;
    obdls_pkg::obdls_err_e ec;
    obdls_top #(.MS_CYC(10)) obdls_top_inst (.clk(clk), .rst(rst), .apb_i(req), .apb_o(rsp),
        .fault_i(flt), .link_act(la), .work_busy(wb), .rx_byte(rb), .rx_valid(rv),
        .host_tx_data(htd), .host_tx_valid(htv), .host_tx_ready(htr), .wake_data(wkd),
        .wake_valid(wkv), .wake_ready(wr), .drv_req(dr), .fb_in(fb), .bus_out(bo),
        .err_code(ec), .err_valid(ev), .busy(by), .rts_n(rn), .host_rxd(rxd), .abort(ab));
    obdls_host_model obdls_host_model_inst (.clk(clk), .tx_data(htd), .tx_valid(htv),
        .tx_ready(htr), .busy(by), .rts_n(rn), .rxd(rxd));
    always #2 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        if (wkv === 1'b1 && wr) wq.push_back(wkd);
        if (ev === 1'b1) eq.push_back(ec);
        if (ab === 1'b1) aborts++;
        if (cyc > 20000)
        begin
            errors++;
            results();
        end
    end
    task results();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic ok, input string m);
        samples_checked++;
        if (!ok)
        begin
            errors++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        req.penable <= 1'b1;
        @(posedge clk);
        while (rsp.pready !== 1'b1) @(posedge clk);
        rd = rsp.prdata;
        sl = rsp.pslverr;
        req <= '0;
    endtask
    task pulse(input logic [8:0] f);
        @(posedge clk);
        flt <= obdls_pkg::obdls_fault_s'(f);
        @(posedge clk);
        flt <= '0;
        repeat (3) @(posedge clk);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_wake();
        apb(0, obdls_pkg::ADDR_WPER, 0);
        chk(rd[15:0] === 16'h0bb8, "interval reset");
        apb(0, 8'h40, 0);
        chk(sl === 1'b1, "unmapped");
        apb(1, obdls_pkg::ADDR_WPER, 32'h2);
        apb(1, obdls_pkg::ADDR_WHDR, 32'h00332211);
        apb(1, obdls_pkg::ADDR_WDAT, 32'h02005544);
        repeat (40) @(posedge clk);
        chk(wq.size() == 0, "wake without link");
        apb(1, obdls_pkg::ADDR_CTRL, 32'h1);
        repeat (6)
        begin
            repeat (10) @(posedge clk);
            la <= 1'b1;
            @(posedge clk);
            la <= 1'b0;
        end
        chk(wq.size() == 0, "wake despite traffic");
        repeat (60) @(posedge clk);
        chk(wq.size() == 6 && wq[0] === 8'h11 && wq[2] === 8'h33 && wq[4] === 8'h55, "msg");
        chk(wq[5] === 8'hff, "checksum");
        rv <= 1'b1;
        @(posedge clk);
        rv <= 1'b0;
        repeat (6) @(posedge clk);
        chk(htv === 1'b0, "reply forwarded");
        apb(1, obdls_pkg::ADDR_CTRL, 32'h0);
        repeat (520) @(posedge clk);
    endtask
    task t_buf();
        obdls_host_model_inst.stall <= 1'b1;
        for (int i = 0; i < 258; i++)
        begin
            rv <= 1'b1;
            rb <= 8'(i);
            @(posedge clk);
        end
        rv <= 1'b0;
        repeat (3) @(posedge clk);
        chk(eq.size() > 0 && eq[eq.size()-1] === 4'h1, "buffer full");
        obdls_host_model_inst.stall <= 1'b0;
        repeat (300) @(posedge clk);
        chk(obdls_host_model_inst.got.size() == 257, "count");
        chk(obdls_host_model_inst.got[255] === 8'hff, "order");
    endtask
    task automatic t_err();
        logic [3:0] c[9] = '{4'h3, 4'h4, 4'hb, 4'ha, 4'h9, 4'h8, 4'h7, 4'h6, 4'h5};
        int n;
        for (int i = 0; i < 9; i++)
        begin
            n = eq.size();
            pulse(9'h1 << i);
            chk(eq.size() == n + 1 && eq[n] === c[i], "fault code");
        end
        dr <= 1'b1;
        fb <= 1'b1;
        repeat (10) @(posedge clk);
        chk(bo === 1'b1, "drive on");
        fb <= 1'b0;
        repeat (262) @(posedge clk);
        chk(bo === 1'b0 && eq[eq.size()-1] === 4'h2, "feedback");
        dr <= 1'b0;
        apb(1, obdls_pkg::ADDR_CTRL, 32'h2);
        n = eq.size();
        pulse(9'h100);
        chk(eq.size() == n, "auto suppress");
        pulse(9'h1);
        chk(eq.size() == n + 1, "auto keeps cmd");
    endtask
    task t_rts();
        wb <= 1'b1;
        repeat (4) @(posedge clk);
        chk(by === 1'b1, "busy");
        obdls_host_model_inst.rts_req();
        repeat (3) @(posedge clk);
        chk(by === 1'b0 && aborts == 1, "abandon");
        obdls_host_model_inst.cmd();
        wb <= 1'b0;
    endtask
    initial
    begin
        {clk, rst, la, wb, rv, dr, fb, rb, errors, samples_checked, cyc, aborts} = '0;
        rst = 1'b1;
        wr = 1'b1;
        req = '0;
        flt = '0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_wake();
        t_buf();
        t_err();
        t_rts();
        results();
    end
endmodule
`default_nettype wire
